/* design/fwc_stage.sv */
/*
 * one cascadable fifo stage with standard and fall-through timing.
 * assumes one clock for write, read and stage transfer, and that the
 * mode straps are held steady while rst_n is low.
 * write and read controls come from logic on the same clock; only the
 * strobe pin is filtered here. groups of stages in width or depth
 * combine their flags outside this block, through gates.
 */
`timescale 1ns/1ps
`include "fwc_params.svh"

// Notes on behaviour
// - fall-through stages chain directly, depths add
// - first word ripples through without read requests
// - word at outputs drives output ready low
// - freed slot bubbles back, input ready low
// - ripple delay only for first word
// - depth 65,536 standard, one more fall-through
// - flag edges may differ one cycle
// - asynchronous read only in standard mode

// in a depth chain the output ready of one stage is the write enable
// of the next, and its input ready the read enable of the one before;
// a stage never merges the flags of its neighbours itself
module fwc_stage (
   input  wire logic                   clk,            // system clock
   input  wire logic                   rst_n,          // master clear
   input  wire logic                   first_word_fall_through_sel,       // strap: fall through
   input  wire logic                   async_rd_sel,   // strap: async read
   input  wire logic                   wr_en_n,        // write enable
   input  wire logic [`FWC_DATA_W-1:0] data_in,        // write data
   input  wire logic                   rd_en_n,        // synchronous read
   input  wire logic                   rd_strobe_n,    // async read pin
   output logic      [`FWC_DATA_W-1:0] data_out,       // read data
   output fwc_pkg::fwc_flags_t         flags,          // status flags
   output fwc_pkg::fwc_mode_t          mode            // latched mode
);

   // the array is as deep as the standard depth; a full fall-through
   // stage holds one word more in its output register
   logic [`FWC_DATA_W-1:0] mem [0:`FWC_MEM_DEPTH-1];
   logic [`FWC_PTR_W-1:0]  wr_ptr_q;
   logic [`FWC_PTR_W-1:0]  rd_ptr_q;
   logic [`FWC_CNT_W-1:0]  count_q;
   logic [`FWC_CNT_W-1:0]  count_d;
   logic [`FWC_DATA_W-1:0] data_q;
   logic                   out_valid_q;
   logic                   out_valid_d;
   fwc_pkg::fwc_mode_t     mode_q;
   fwc_pkg::fwc_flags_t    flags_q;
   fwc_pkg::fwc_flags_t    flags_d;
   // strobe pin filter
   logic [2:0]             strobe_sync_q;
   logic                   strobe_lvl_q;
   logic                   strobe_agree;
   logic                   async_pulse;
   // request and occupancy decode
   logic                   mem_empty;
   logic                   mem_full;
   logic                   wr_take;
   logic                   pop_out;
   logic                   std_req;
   logic                   load;
   logic [`FWC_CNT_W-1:0]  cnt_up;
   logic [`FWC_CNT_W-1:0]  cnt_down;
   // next-state flag decode for both timings
   logic                   nxt_empty;
   logic                   nxt_full;
   logic                   ft_out_n;
   logic                   ft_in_n;
   logic                   std_out_n;
   logic                   std_in_n;

   // occupancy compares, used for the live and the next count alike
   function automatic logic cnt_is_empty(input logic [`FWC_CNT_W-1:0] c);
      cnt_is_empty = (c == `FWC_CNT_ZERO);
   endfunction

   function automatic logic cnt_is_full(input logic [`FWC_CNT_W-1:0] c);
      cnt_is_full = (c == `FWC_MEM_DEPTH);
   endfunction

   // array state decode
   assign mem_empty = cnt_is_empty(count_q);
   assign mem_full  = cnt_is_full(count_q);

   // strobe pin filter: a level counts once stages two and three agree
   assign strobe_agree = (strobe_sync_q[1] == strobe_sync_q[2]);
   assign async_pulse  = strobe_lvl_q & strobe_agree & ~strobe_sync_q[2];

   // write when enabled and room; full refuses silently
   assign wr_take = ~wr_en_n & ~mem_full;

   // fall-through: the output word leaves when downstream reads it
   assign pop_out = mode_q.fall_through & out_valid_q & ~rd_en_n;

   // standard read request; the strobe pin is ignored in fall-through
   assign std_req = mode_q.async_read & ~mode_q.fall_through ?
                    async_pulse : ~rd_en_n;

   // a word waiting in the output register blocks further loads;
   // fall-through loads the output word without any read request, so
   // only the first word into an empty stage sees the extra cycle
   assign load = ~mem_empty &
                 (mode_q.fall_through ? (~out_valid_q | pop_out)
                                      : std_req);

   // occupancy of the array; the output word in fall-through adds one
   assign count_d = count_q + cnt_up - cnt_down;

   // one step up per write, one down per load; both in one cycle cancel
   assign cnt_up   = wr_take ? `FWC_CNT_ONE : `FWC_CNT_ZERO;
   assign cnt_down = load    ? `FWC_CNT_ONE : `FWC_CNT_ZERO;

   assign out_valid_d = mode_q.fall_through &
                        (load | (out_valid_q & ~pop_out));

   // next-state occupancy decode; full feeds both flag timings, empty only standard
   assign nxt_empty = cnt_is_empty(count_d);
   assign nxt_full  = cnt_is_full(count_d);

   // fall-through: output ready low with a word present, input ready
   // low while the array has room; the output word is one slot more
   assign ft_out_n = ~out_valid_d;
   assign ft_in_n  = nxt_full;

   // standard: empty and full flags are low while that state holds
   assign std_out_n = ~nxt_empty;
   assign std_in_n  = ~nxt_full;

   // flags from next state so they stand in step with the data word
   assign flags_d.out_status_n = mode_q.fall_through ? ft_out_n
                                                    : std_out_n;
   assign flags_d.in_status_n  = mode_q.fall_through ? ft_in_n
                                                    : std_in_n;

   // mode straps are caught while the clear is held, frozen after
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_q.fall_through <= first_word_fall_through_sel;
         mode_q.async_read   <= async_rd_sel;
      end
   end

   // strobe pin synchroniser, three stages; only stage two feeds stage
   // three and the agree test, so an unsettled first stage never
   // reaches the read logic
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         strobe_sync_q <= `FWC_SYNC_RST;
         strobe_lvl_q  <= 1'b1;
      end else begin
         strobe_sync_q <= {strobe_sync_q[1:0], rd_strobe_n};
         if (strobe_agree) begin
            strobe_lvl_q <= strobe_sync_q[2];
         end
      end
   end

   // storage array has no reset; contents are dont-care until written
   always_ff @(posedge clk) begin
      if (wr_take) begin
         mem[wr_ptr_q] <= data_in;
      end
   end

   // write pointer advances on every accepted word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
      end else if (wr_take) begin
         wr_ptr_q <= wr_ptr_q + `FWC_PTR_ONE;
      end
   end

   // read pointer and output word move together on a load
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_ptr_q <= '0;
         data_q   <= '0;
      end else if (load) begin
         rd_ptr_q <= rd_ptr_q + `FWC_PTR_ONE;
         data_q   <= mem[rd_ptr_q];
      end
   end

   // occupancy and output word presence
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q     <= `FWC_CNT_ZERO;
         out_valid_q <= 1'b0;
      end else begin
         count_q     <= count_d;
         out_valid_q <= out_valid_d;
      end
   end

   // registered flags; stages side by side may see their edges one
   // cycle apart, so a width group must combine them outside
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q.out_status_n <= first_word_fall_through_sel;
         flags_q.in_status_n  <= ~first_word_fall_through_sel;
      end else begin
         flags_q <= flags_d;
      end
   end

   // every output comes straight from a register
   assign data_out = data_q;
   assign flags    = flags_q;
   assign mode     = mode_q;

endmodule

/* design/fwc_params.svh */
/*
 * constants of the cascadable fifo stage: widths, depths, reset values.
 * assumes it is included by bare name from the package and the stage.
 */
`ifndef FWC_PARAMS_SVH
`define FWC_PARAMS_SVH

`define FWC_DATA_W      36
`define FWC_PTR_W       16
`define FWC_CNT_W       17
`define FWC_MEM_DEPTH   17'h10000
`define FWC_PTR_ONE     16'h0001
`define FWC_CNT_ONE     17'h00001
`define FWC_CNT_ZERO    17'h00000
`define FWC_SYNC_RST    3'h7

`endif

/* design/fwc_pkg.sv */
/*
 * types shared by the cascadable fifo stage.
 * assumes fwc_params.svh is on the include path.
 */
`include "fwc_params.svh"

package fwc_pkg;

   // mode straps caught while the master clear is held
   typedef struct packed {
      logic fall_through;   // first word fall through timing
      logic async_read;     // read strobe pin used, standard mode only
   } fwc_mode_t;

   // status flags as driven on the pins, all active low
   typedef struct packed {
      logic out_status_n;   // empty flag / output ready
      logic in_status_n;    // full indicator / input ready
   } fwc_flags_t;

endpackage

/* sim/fwc_stage_assertions.sv */
/* pin checks of one fifo stage; assumes one clock and sync reset */
`timescale 1ns/1ps
module fwc_chk (
   input wire logic          clk,      // clock
   input wire logic          rst_n,    // clear
   input wire logic          first_word_fall_through_sel, // strap
   input wire logic          wr_en_n,  // write
   input wire logic [35:0]   data_in,  // wdata
   input wire logic          rd_en_n,  // read
   input wire logic [35:0]   data_out, // rdata
   input fwc_pkg::fwc_flags_t flags,   // flags
   input fwc_pkg::fwc_mode_t  mode     // mode
);
   // short names keep the properties on few lines
   wire logic o = flags.out_status_n;
   wire logic i = flags.in_status_n;
   wire logic f = mode.fall_through;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // reset values must hold during the clear itself, so no disable there
   rst_flag_a: assert property (disable iff (1'b0) !rst_n |=>
      {o, i} == {$past(first_word_fall_through_sel), !$past(first_word_fall_through_sel)}) else $error("rst");
   mode_cap_a: assert property (disable iff (1'b0) !rst_n |=>
      f == $past(first_word_fall_through_sel)) else $error("cap");
   mode_hold_a: assert property (rst_n |=> $stable(mode))
      else $error("mode");
   // a word into an empty stage shows two edges later
   ready_lo_a: assert property (f && o && !i && !wr_en_n |-> ##2 !o)
      else $error("ready");
   first_wd_a: assert property (f && o && !wr_en_n && $past(o) &&
      $past(wr_en_n) |-> ##2 data_out == $past(data_in, 2)) else $error("w");
   slot_free_a: assert property (f && i && !o && !rd_en_n && wr_en_n
      |-> ##[1:2] !i) else $error("bubble");
   word_hold_a: assert property (f && !o && rd_en_n |=> !o &&
      $stable(data_out)) else $error("hold");
   std_clr_a: assert property (!f && !o && !wr_en_n |=> o)
      else $error("empty");
   cover property (f && i);
   cover property (!f && o && !rd_en_n);
   cover property (f && !o && !rd_en_n);
endmodule
bind fwc_stage fwc_chk u_chk (.clk(clk), .rst_n(rst_n), .first_word_fall_through_sel(first_word_fall_through_sel),
   .wr_en_n(wr_en_n), .data_in(data_in), .rd_en_n(rd_en_n),
   .data_out(data_out), .flags(flags), .mode(mode));

/* sim/fwc_sink.sv */
/* downstream sink: pops unless stalled, keeps the last word taken */
`timescale 1ns/1ps
module fwc_sink (
   input wire logic        clk,     // clock
   input wire logic        rdy_n,   // word present
   input wire logic [35:0] d,       // stage data
   input wire logic        stall,   // hold off
   output logic            rd_en_n, // pop
   output logic [35:0]     got      // last word
);
   // read side clocked freely; request only while not stalled
   assign rd_en_n = stall;
   always_ff @(posedge clk) if (!rd_en_n && !rdy_n) got <= d;
endmodule

/* sim/testbench.sv */
/* stage bench: fall-through fill and pop, then standard reads */
`timescale 1ns/1ps
module testbench;
   logic                clk = 1'b0, rst_n = 1'b0, fw = 1'b1;
   logic                wr_n = 1'b1, st_n = 1'b1, stall = 1'b1, rd_n;
   logic                ar = 1'b1, o_all, i_all;
   logic [35:0]         dout_hi;
   fwc_pkg::fwc_flags_t fl_hi;
   logic [35:0]         din = 36'h0, dout, got;
   fwc_pkg::fwc_flags_t fl;
   fwc_pkg::fwc_mode_t  md;
   int                  n_fail = 0, num_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   fwc_stage dut (.clk(clk), .rst_n(rst_n), .first_word_fall_through_sel(fw),
      .async_rd_sel(ar), .wr_en_n(wr_n), .data_in(din), .rd_en_n(rd_n),
      .rd_strobe_n(st_n), .data_out(dout), .flags(fl), .mode(md));
   fwc_sink snk (.clk(clk), .rdy_n(fl.out_status_n), .d(dout),
      .stall(stall), .rd_en_n(rd_n), .got(got));
   // upper half of a 72-bit pair: same depth, same controls
   fwc_stage dut_hi (.clk(clk), .rst_n(rst_n), .first_word_fall_through_sel(fw),
      .async_rd_sel(ar), .wr_en_n(wr_n), .data_in(~din), .rd_en_n(rd_n),
      .rd_strobe_n(st_n), .data_out(dout_hi), .flags(fl_hi), .mode());
   // composite flags through gates, never wired together
   assign o_all = fw ? (fl.out_status_n | fl_hi.out_status_n)
                     : (fl.out_status_n & fl_hi.out_status_n);
   assign i_all = fw ? (fl.in_status_n | fl_hi.in_status_n)
                     : (fl.in_status_n & fl_hi.in_status_n);
   task automatic t(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic c(logic [35:0] e, logic [35:0] g, string nm);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // write is left asserted so fills run back to back
   task automatic w(logic [35:0] d);
      din = d;
      wr_n = 1'b0;
      t(1);
   endtask
   // strobe pulse, then time for the filter to see the pin high again
   task automatic s();
      st_n = 1'b0;
      t(6);
      st_n = 1'b1;
      t(4);
   endtask
   // one read request lasting one cycle
   task automatic p();
      stall = 1'b0;
      t(1);
      stall = 1'b1;
      t(2);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // a full fill alone takes some 65.5k cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc > 70000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      t(16);
      rst_n = 1'b1;
      c(36'he, {32'h0, md, fl}, "mode");
      w(36'h5a5);
      wr_n = 1'b1;
      t(2);
      c(36'h5a4, {dout[35:1], fl.out_status_n}, "first");
      c(36'hffffffa5a, dout_hi, "wide");
      c(36'h0, {35'h0, o_all}, "ready all");
      s();
      c(36'h5a5, dout, "strobe");
      for (int k = 1; k < 65536; k++) w(36'(k));
      wr_n = 1'b1;
      t(2);
      c(36'h0, {35'h0, fl.in_status_n}, "room");
      w(36'h10000);
      w(36'hbad);
      wr_n = 1'b1;
      t(2);
      c(36'h1, {35'h0, fl.in_status_n}, "full");
      c(36'h1, {35'h0, i_all}, "full all");
      p();
      c(36'h5a5, got, "pop");
      c(36'h2, {dout[34:0], fl.in_status_n}, "next");
      p();
      c(36'h1, got, "pop2");
      $display("fall-through test done");
      rst_n = 1'b0;
      fw = 1'b0;
      t(16);
      rst_n = 1'b1;
      w(36'h11);
      w(36'h22);
      wr_n = 1'b1;
      s();
      c(36'h11, dout, "async");
      s();
      c(36'h44, {dout[34:0], fl.out_status_n}, "async2");
      c(36'h0, {35'h0, o_all}, "empty all");
      $display("standard strobe test done");
      rst_n = 1'b0;
      ar = 1'b0;
      t(16);
      rst_n = 1'b1;
      w(36'h33);
      wr_n = 1'b1;
      t(1);
      c(36'h1, {35'h0, fl.out_status_n}, "not empty");
      p();
      c(36'h66, {dout[34:0], fl.out_status_n}, "sync");
      $display("standard test done");
      report_and_stop();
   end
endmodule
